// ---- logic/pmc_pkg.sv ----
// constants and carrier types for the power-mode and reset-cause controller
`default_nettype none
package pmc_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // register offsets on the special-function bus
    localparam logic [7:0] OFS_POWER_DOWN_CONTROL     = 8'ha4;
    localparam logic [7:0] OFS_OPERATING_MODE_CONTROL = 8'hae;
    localparam logic [7:0] OFS_RESET_CAUSE            = 8'hb1;

    // reset values
    localparam logic [7:0] RST_POWER_DOWN_CONTROL     = 8'h00;
    localparam logic [7:0] RST_OPERATING_MODE_CONTROL = 8'h00;
    localparam logic [2:0] RST_RESET_CAUSE            = 3'h0;

    // power_down_control fields
    localparam int unsigned PDC_WAKE_PIN_BIT  = 7;
    localparam int unsigned PDC_WAKE_TICK_BIT = 6;
    localparam int unsigned PDC_WAKE_CMP_BIT  = 5;
    localparam int unsigned PDC_MODE_LSB      = 0;
    localparam int unsigned PDC_MODE_W        = 3;

    // operating_mode_control fields
    localparam int unsigned OMC_PIN_POL_BIT  = 2;
    localparam int unsigned OMC_LATCH_BIT    = 1;
    localparam int unsigned OMC_WDOG_RST_BIT = 0;
    localparam logic [7:0]  OMC_WRITE_MASK   = 8'h07;

    // reset_cause fields
    localparam int unsigned RC_PIN_BIT  = 0;
    localparam int unsigned RC_WDOG_BIT = 1;

    // mode codes, shared by write and read-back
    localparam logic [2:0] MODE_ACTIVE     = 3'h0;
    localparam logic [2:0] MODE_DEEP_SLEEP = 3'h1;
    localparam logic [2:0] MODE_MEM_RET_TO = 3'h2;
    localparam logic [2:0] MODE_MEM_RET_TN = 3'h3;
    localparam logic [2:0] MODE_REG_RET    = 3'h4;
    localparam logic [2:0] MODE_RSVD_5     = 3'h5;
    localparam logic [2:0] MODE_RSVD_6     = 3'h6;
    localparam logic [2:0] MODE_STANDBY    = 3'h7;

    // number of wakeup pins; polarity is selectable on a subset of them
    localparam int unsigned WAKE_PINS = 16;

    typedef enum logic [1:0] {
        PMC_RUN,
        PMC_ASLEEP,
        PMC_WAKING
    } pmc_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } pmc_bus_req_t;

    typedef struct packed {
        logic pin;
        logic tick;
        logic cmp;
    } pmc_wake_t;

    typedef struct packed {
        logic deep_sleep;
        logic mem_ret_timer_off;
        logic mem_ret_timer_on;
        logic reg_ret;
        logic standby;
    } pmc_mode_onehot_t;

endpackage : pmc_pkg
`default_nettype wire

// ---- logic/pmc_sync.sv ----
// two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/100ps
`default_nettype none
module pmc_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock, reset, enable
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_stage1   = stage1;
        next_sync_out = sync_out;
        if (sys_rst) begin
            next_stage1   = '0;
            next_sync_out = '0;
        end else if (clk_en) begin
            next_stage1   = async_in;
            next_sync_out = stage1;
        end
    end

    always_ff @(posedge ref_clk) begin
        stage1   <= next_stage1;
        sync_out <= next_sync_out;
    end

endmodule : pmc_sync
`default_nettype wire

// ---- logic/pmc_ctrl.sv ----
// power-mode and reset-cause control registers and sequencing
// Operation
// - mode write of 001-100 or 111 leaves active mode and enters the coded power-saving mode
// - decode 001 deep,010/011 memory retention,100 register retention,111 standby
// - mode field read returns previous power-down mode, 000 meaning power off
// - bit 7 flags the last wakeup came from a wakeup pin
// - bit 6 flags the last wakeup came from the timer tick
// - bit 5 flags the last wakeup came from the comparator
// - wakeup flags clear on a power-down control read or on entering any power-down mode
// - operating-mode bit 2 selects active-low polarity for a subset of wakeup pins
// - operating-mode bit 1 locks the retention latches; zero passes through
// - with bit 0 clear, watchdog runs in every mode but deepest sleep
// - with bit 0 set, watchdog held in reset in memory or register retention
// - generator, pin and watchdog resets all start the same reset sequence
// - reset cause bit 0 means pin reset, bit 1 watchdog, zero the generator
// - any write to reset cause clears every bit
// - reset cause bits accumulate until generator reset or a write
// - low-frequency clock is the roughly 32 kHz clock chosen elsewhere
`timescale 1ns/100ps
`default_nettype none
module pmc_ctrl
    import pmc_pkg::*;
#(
    parameter int unsigned NUM_WAKE_PINS = WAKE_PINS,
    parameter logic [NUM_WAKE_PINS-1:0] POL_SELECTABLE = 16'h0044
) (
    // clock, reset, enable
    input  wire logic                     ref_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     clk_en,
    // register port
    input  wire logic [ADDR_W-1:0]        reg_addr,
    input  wire logic [DATA_W-1:0]        reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [DATA_W-1:0]        reg_rdata,
    // reset sources, asynchronous levels
    input  wire logic                     por_reset_req,
    input  wire logic                     pin_reset_req,
    input  wire logic                     wdog_reset_req,
    // wakeup events from outside the clock domain
    input  wire logic [NUM_WAKE_PINS-1:0] wake_pins_raw,
    input  wire logic [NUM_WAKE_PINS-1:0] wake_pin_enable,
    input  wire logic                     wake_tick,
    input  wire logic                     wake_cmp,
    // power and system control
    output logic                          chip_reset,
    output logic [2:0]                    power_mode,
    output logic                          in_power_down,
    output logic                          mcu_clk_stop,
    output logic                          retention_latch_lock,
    output logic                          wdog_hold_reset,
    output logic                          wdog_power_off,
    output logic [NUM_WAKE_PINS-1:0]      wake_pins_active
);

    // decoding shared by write path and status
    function automatic logic mode_is_power_down(input logic [2:0] code);
        return (code != MODE_ACTIVE) && (code != MODE_RSVD_5) && (code != MODE_RSVD_6);
    endfunction

    function automatic logic mode_is_retention(input logic [2:0] code);
        return (code == MODE_MEM_RET_TO) || (code == MODE_MEM_RET_TN)
            || (code == MODE_REG_RET);
    endfunction

    // synchronised external levels
    localparam int unsigned SYNC_W = NUM_WAKE_PINS + 5;
    logic [SYNC_W-1:0] sync_q;
    logic [NUM_WAKE_PINS-1:0] pins_s;
    logic tick_s, cmp_s, por_s, pin_rst_s, wdog_rst_s;

    pmc_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .async_in ({wake_pins_raw, wake_tick, wake_cmp,
                    por_reset_req, pin_reset_req, wdog_reset_req}),
        .sync_out (sync_q)
    );

    assign pins_s     = sync_q[SYNC_W-1:5];
    assign tick_s     = sync_q[4];
    assign cmp_s      = sync_q[3];
    assign por_s      = sync_q[2];
    assign pin_rst_s  = sync_q[1];
    assign wdog_rst_s = sync_q[0];

    pmc_bus_req_t req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    logic hit_pdc, hit_omc, hit_rc;
    assign hit_pdc = (req.addr == OFS_POWER_DOWN_CONTROL);
    assign hit_omc = (req.addr == OFS_OPERATING_MODE_CONTROL);
    assign hit_rc  = (req.addr == OFS_RESET_CAUSE);

    // polarity selection of wakeup pins
    logic [NUM_WAKE_PINS-1:0] pin_level;
    logic [7:0] omc;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_WAKE_PINS; gi++) begin : g_pol
            assign pin_level[gi] = (POL_SELECTABLE[gi] && omc[OMC_PIN_POL_BIT])
                                   ? ~pins_s[gi] : pins_s[gi];
        end
    endgenerate

    logic pin_wake;
    assign pin_wake = |(pin_level & wake_pin_enable);

    // state
    pmc_state_t state, next_state;
    logic [2:0] cur_mode, next_cur_mode;
    logic [2:0] prev_mode, next_prev_mode;
    logic [7:0] next_omc;
    pmc_wake_t  wake_flags, next_wake_flags;
    logic [2:0] rc, next_rc;
    logic       any_rst_q, next_any_rst_q;
    logic [DATA_W-1:0] next_rdata;
    pmc_wake_t  wake_ev;
    logic       any_rst;

    assign wake_ev = '{pin: pin_wake, tick: tick_s, cmp: cmp_s};
    // all sources funnel into one reset so start-up is identical
    assign any_rst = por_s | pin_rst_s | wdog_rst_s;

    always_comb begin
        next_state      = state;
        next_cur_mode   = cur_mode;
        next_prev_mode  = prev_mode;
        next_omc        = omc;
        next_wake_flags = wake_flags;
        next_rc         = rc;
        next_any_rst_q  = any_rst;
        next_rdata      = '0;
        if (clk_en) begin
            // reads answer one cycle later; a power-down control read clears wakeup flags
            if (req.rd) begin
                if (hit_pdc) begin
                    next_rdata = {wake_flags.pin, wake_flags.tick, wake_flags.cmp,
                                  2'b00, prev_mode};
                    next_wake_flags = '0;
                end else if (hit_omc) begin
                    next_rdata = omc;
                end else if (hit_rc) begin
                    next_rdata = {5'b00000, rc};
                end
            end
            if (req.wr && hit_omc) begin
                next_omc = req.wdata & OMC_WRITE_MASK;
            end
            case (state)
                PMC_RUN: begin
                    if (req.wr && hit_pdc) begin
                        if (mode_is_power_down(req.wdata[2:0])) begin
                            next_cur_mode   = req.wdata[2:0];
                            next_wake_flags = '0;
                            next_state      = PMC_ASLEEP;
                        end else begin
                            next_cur_mode = MODE_ACTIVE;
                        end
                    end
                end
                PMC_ASLEEP: begin
                    if (|wake_ev) begin
                        next_wake_flags = wake_ev;
                        next_state      = PMC_WAKING;
                    end
                end
                PMC_WAKING: begin
                    next_prev_mode = cur_mode;
                    next_cur_mode  = MODE_ACTIVE;
                    next_state     = PMC_RUN;
                end
                default: begin
                    next_state = PMC_RUN;
                end
            endcase
            // write clears, then new reset causes set on top
            if (req.wr && hit_rc) begin
                next_rc = RST_RESET_CAUSE;
            end
            if (pin_rst_s) begin
                next_rc[RC_PIN_BIT] = 1'b1;
            end
            if (wdog_rst_s) begin
                next_rc[RC_WDOG_BIT] = 1'b1;
            end
            // a generator reset wipes history; an external reset keeps it
            if (por_s) begin
                next_rc = RST_RESET_CAUSE;
            end
            if (any_rst) begin
                next_state      = PMC_RUN;
                next_cur_mode   = MODE_ACTIVE;
                next_prev_mode  = MODE_ACTIVE;
                next_omc        = RST_OPERATING_MODE_CONTROL;
                next_wake_flags = '0;
            end
        end else begin
            // a frozen cycle keeps the read data as well
            next_any_rst_q = any_rst_q;
            next_rdata     = reg_rdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state      <= PMC_RUN;
            cur_mode   <= MODE_ACTIVE;
            prev_mode  <= MODE_ACTIVE;
            omc        <= RST_OPERATING_MODE_CONTROL;
            wake_flags <= '0;
            rc         <= RST_RESET_CAUSE;
            any_rst_q  <= 1'b0;
            reg_rdata  <= '0;
        end else begin
            state      <= next_state;
            cur_mode   <= next_cur_mode;
            prev_mode  <= next_prev_mode;
            omc        <= next_omc;
            wake_flags <= next_wake_flags;
            rc         <= next_rc;
            any_rst_q  <= next_any_rst_q;
            reg_rdata  <= next_rdata;
        end
    end

    // outputs
    logic asleep;
    assign asleep           = (state == PMC_ASLEEP);
    assign chip_reset       = any_rst_q;
    assign power_mode       = asleep ? cur_mode : MODE_ACTIVE;
    assign in_power_down    = asleep;
    assign mcu_clk_stop     = asleep && (cur_mode == MODE_STANDBY);
    assign retention_latch_lock = omc[OMC_LATCH_BIT];
    // hold watchdog in reset through retention only when enabled
    assign wdog_hold_reset  = asleep && omc[OMC_WDOG_RST_BIT]
                              && mode_is_retention(cur_mode);
    // deepest sleep removes watchdog power regardless of the enable
    assign wdog_power_off   = asleep && (cur_mode == MODE_DEEP_SLEEP);
    assign wake_pins_active = pin_level;

endmodule : pmc_ctrl
`default_nettype wire

// ---- bench/pmc_ctrl_asserts.sv ----
// port-level assertions for the power-mode and reset-cause controller
`timescale 1ns/100ps
`default_nettype none
module pmc_ctrl_asserts
    import pmc_pkg::*;
(
    // clock and reset
    input wire logic              ref_clk,
    input wire logic              sys_rst,
    input wire logic              clk_en,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // reset sources and wakeup
    input wire logic              por_reset_req,
    input wire logic              pin_reset_req,
    input wire logic              wdog_reset_req,
    input wire logic              wake_tick,
    // control outputs
    input wire logic              chip_reset,
    input wire logic [2:0]        power_mode,
    input wire logic              in_power_down,
    input wire logic              retention_latch_lock,
    input wire logic              wdog_hold_reset,
    input wire logic              wdog_power_off
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence pdc_write_s;
        reg_wr && clk_en && !chip_reset && !in_power_down && reg_addr == OFS_POWER_DOWN_CONTROL;
    endsequence
    sequence req_held_s;
        (clk_en && (por_reset_req || pin_reset_req || wdog_reset_req))[*5];
    endsequence
    // timer-on retention and standby are the modes where the tick is known to be live
    sequence tick_asleep_s;
        (in_power_down && wake_tick && clk_en && power_mode inside {3'h3, 3'h7})
            ##1 (wake_tick && clk_en)[*5];
    endsequence

    mode_enter_a: assert property (
        pdc_write_s ##0 (reg_wdata[2:0] inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h7})
        |=> in_power_down && {5'h0, power_mode} == ($past(reg_wdata) & 8'h07))
        else $error("mode write did not enter the coded mode");
    reserved_idle_a: assert property (
        pdc_write_s ##0 (reg_wdata[2:0] inside {3'h0, 3'h5, 3'h6}) |=> !in_power_down)
        else $error("reserved or zero mode write entered power down");
    deep_wdog_off_a: assert property (
        wdog_power_off == (in_power_down && power_mode == MODE_DEEP_SLEEP))
        else $error("watchdog power-off out of step with deepest sleep");
    wdog_hold_a: assert property (
        wdog_hold_reset |-> in_power_down && power_mode inside {3'h2, 3'h3, 3'h4})
        else $error("watchdog held in reset outside retention");
    rdata_idle_a: assert property (
        $past(clk_en) && (!$past(reg_rd) || !($past(reg_addr) inside {8'ha4, 8'hae, 8'hb1}))
        |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a mapped read");
    latch_follow_a: assert property (
        reg_wr && clk_en && !chip_reset && reg_addr == OFS_OPERATING_MODE_CONTROL
        |=> retention_latch_lock == |($past(reg_wdata) & 8'h02))
        else $error("latch lock does not follow its bit");
    reset_req_a: assert property (req_held_s |-> chip_reset)
        else $error("reset request did not reach chip reset");
    tick_wake_a: assert property (tick_asleep_s |-> !in_power_down)
        else $error("tick did not wake the system in time");
endmodule : pmc_ctrl_asserts
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the power-mode and reset-cause controller
`timescale 1ns/100ps
`default_nettype none
module testbench
    import pmc_pkg::*;
;
    localparam logic [15:0] POL = 16'h0044;
    logic        ref_clk   = 1'b0;
    logic        sys_rst   = 1'b1;
    logic        clk_en    = 1'b1;
    logic [7:0]  reg_addr  = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [2:0]  req       = 3'h0;
    logic [2:0]  wake      = 3'h0;
    logic        omc0      = 1'b0;
    logic [7:0]  rsv [3]   = '{8'h00, 8'h05, 8'h06};
    logic [7:0]  reg_rdata;
    logic [15:0] pins_act;
    logic [2:0]  power_mode;
    logic        chip_reset, in_pd, clk_stop, latch, hold, poff;
    int          error_cnt = 0;
    int          n_checks  = 0;
    int          cyc       = 0;

    // wake is one-hot pin, tick, comparator, the same order as the flag bits
    pmc_ctrl #(.POL_SELECTABLE(POL)) pmc_ctrl_i (
        .ref_clk, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .por_reset_req(req[0]), .pin_reset_req(req[1]), .wdog_reset_req(req[2]),
        .wake_pins_raw({15'h0, wake[2]}), .wake_pin_enable(16'h0001),
        .wake_tick(wake[1]), .wake_cmp(wake[0]), .chip_reset, .power_mode,
        .in_power_down(in_pd), .mcu_clk_stop(clk_stop), .retention_latch_lock(latch),
        .wdog_hold_reset(hold), .wdog_power_off(poff), .wake_pins_active(pins_act));

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    // sleep in one mode, wake from one source, optionally read the flags back
    task automatic nap(input logic [2:0] code, input logic [2:0] src, input bit look);
        wr(OFS_POWER_DOWN_CONTROL, {5'h0, code});
        chk(in_pd, 1'b1);
        chk(power_mode, code);
        chk(clk_stop, code == MODE_STANDBY);
        chk(poff, code == MODE_DEEP_SLEEP);
        chk(hold, omc0 && code inside {3'h2, 3'h3, 3'h4});
        @(posedge ref_clk);
        wake <= src;
        for (int i = 0; i < 20 && in_pd !== 1'b0; i++) @(posedge ref_clk) #1;
        chk(in_pd, 1'b0);
        // the source stays up a little so the tick-wake assertion gets exercised
        repeat (3) @(posedge ref_clk);
        wake <= 3'h0;
        if (look) begin
            rd(OFS_POWER_DOWN_CONTROL, {src, 2'b00, code});
            rd(OFS_POWER_DOWN_CONTROL, {5'h0, code});
        end
        wr(OFS_POWER_DOWN_CONTROL, 8'h00);
    endtask : nap

    // a write seen while the enable is low must be lost
    task automatic freeze_test();
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr(OFS_OPERATING_MODE_CONTROL, 8'h02);
        chk(latch, 1'b0);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        rd(OFS_OPERATING_MODE_CONTROL, 8'h00);
    endtask : freeze_test

    task automatic omc_test();
        wr(OFS_OPERATING_MODE_CONTROL, 8'h07);
        rd(OFS_OPERATING_MODE_CONTROL, 8'h07);
        chk(latch, 1'b1);
        repeat (3) @(posedge ref_clk) #1;
        chk(pins_act, POL);
        wr(OFS_OPERATING_MODE_CONTROL, 8'h01);
        repeat (3) @(posedge ref_clk) #1;
        chk(pins_act, 16'h0000);
        chk(latch, 1'b0);
        omc0 = 1'b1;
    endtask : omc_test

    task automatic mode_test();
        wr(OFS_OPERATING_MODE_CONTROL, 8'h03);
        // one low-frequency period covers its first falling edge
        repeat (800) @(posedge ref_clk);
        nap(MODE_MEM_RET_TO, 3'b001, 1'b1);
        nap(MODE_REG_RET, 3'b001, 1'b0);
        nap(MODE_MEM_RET_TN, 3'b010, 1'b1);
        wr(OFS_OPERATING_MODE_CONTROL, 8'h02);
        omc0 = 1'b0;
        nap(MODE_DEEP_SLEEP, 3'b100, 1'b1);
        nap(MODE_STANDBY, 3'b010, 1'b1);
        nap(MODE_MEM_RET_TN, 3'b001, 1'b1);
        foreach (rsv[i]) begin
            wr(OFS_POWER_DOWN_CONTROL, rsv[i]);
            repeat (2) @(posedge ref_clk) #1;
            chk(in_pd, 1'b0);
            rd(OFS_POWER_DOWN_CONTROL, {5'h0, MODE_MEM_RET_TN});
        end
    endtask : mode_test

    task automatic pulse(input int k);
        @(posedge ref_clk);
        req[k] <= 1'b1;
        repeat (5) @(posedge ref_clk);
        req[k] <= 1'b0;
        #1;
        chk(chip_reset, 1'b1);
        repeat (8) @(posedge ref_clk);
        #1;
        chk(chip_reset, 1'b0);
    endtask : pulse

    task automatic cause_test();
        wr(OFS_OPERATING_MODE_CONTROL, 8'h02);
        pulse(1);
        rd(OFS_RESET_CAUSE, 8'h01);
        rd(OFS_OPERATING_MODE_CONTROL, 8'h00);
        pulse(2);
        rd(OFS_RESET_CAUSE, 8'h03);
        wr(OFS_RESET_CAUSE, 8'h5a);
        rd(OFS_RESET_CAUSE, 8'h00);
        pulse(2);
        rd(OFS_RESET_CAUSE, 8'h02);
        pulse(0);
        rd(OFS_RESET_CAUSE, 8'h00);
    endtask : cause_test

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            finish_test();
        end
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(OFS_POWER_DOWN_CONTROL, 8'h00);
        rd(OFS_OPERATING_MODE_CONTROL, 8'h00);
        rd(OFS_RESET_CAUSE, 8'h00);
        rd(8'h55, 8'h00);
        freeze_test();
        omc_test();
        mode_test();
        cause_test();
        finish_test();
    end
endmodule : testbench

bind pmc_ctrl pmc_ctrl_asserts pmc_ctrl_asserts_i (
    .ref_clk, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .por_reset_req, .pin_reset_req, .wdog_reset_req, .wake_tick, .chip_reset, .power_mode,
    .in_power_down, .retention_latch_lock, .wdog_hold_reset, .wdog_power_off);
`default_nettype wire
